// ===== hdl/upper_address_pin_mux.sv
// Overview of operation
// - Boot select low at reset gives the four pins to parallel general-purpose I/O bits 3..0.
// - Boot select high at reset gives the four pins to external memory address bits 21..18.
// - The function is fixed on reset release and kept until the next reset.
// - Bus holders are on after reset and software switches them in the bus control register.
// - In general-purpose mode all four lines come out of reset as inputs.
// - In address mode the pins float during reset, then drive zero for one cycle before the address.
// - The pins float while the hold input requests the bus.
// - During hold a memory clock output keeps toggling when its float select is 0.
// - During hold a memory clock output floats when its float select is 1.
// - The pins float in all-float mode: test reset 0, emulation 0 high, emulation 1 low.
// - In general-purpose mode software sets each pin as input or output.
// - Enabled holders keep each line at its last driven level once the bus floats.
`timescale 1ns/1ps
module upper_address_pin_mux (
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   input  wire logic                       clk_en,
   input  wire logic [4:0]                 avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [3:0]                 avs_byteenable,
   input  wire logic [31:0]                avs_writedata,
   output logic [31:0]                     avs_readdata,
   output logic                            avs_waitrequest,
   input  wire upper_address_pkg::pin_in_t pins_in,
   input  wire logic [3:0]                 ext_mem_upper_address,
   output upper_address_pkg::pad_drive_t   pad_drive,
   output logic [3:0]                      holder_oe,
   output logic [3:0]                      holder_level,
   output logic [1:0]                      ext_mem_clock_out,
   output logic [1:0]                      ext_mem_clock_oe,
   output logic                            function_select
);
   import upper_address_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      hit = (addr[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB]);
   endfunction

   // Pin synchronisers
   pin_in_t meta_q;
   pin_in_t meta_d;
   pin_in_t sync_q;
   pin_in_t sync_d;

   always_comb begin
      meta_d = pins_in;
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   logic hold_s;
   logic off_s;

   assign hold_s = ~sync_q.hold_request_n;
   assign off_s  = ~sync_q.test_reset_n & sync_q.emulation_pin_0 & ~sync_q.emulation_pin_1_float;

   // Boot select sampling; no async reset so it can follow the pin during reset
   logic boot_q;
   logic boot_d;

   always_comb begin
      boot_d = reset ? sync_q.boot_select_pin : boot_q;
   end

   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         boot_q <= boot_d;
      end
   end

   // Function select state
   mux_state_t state_q;
   mux_state_t state_d;

   always_comb begin
      unique case (state_q)
         ST_RESET:   state_d = boot_q ? ST_EXT_MEM : ST_GPIO;
         ST_GPIO:    state_d = state_q;
         ST_EXT_MEM: state_d = state_q;
         default:    state_d = ST_RESET;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_RESET;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   assign function_select = (state_q == ST_EXT_MEM);

   // Avalon slave, one wait state on every access
   logic                 ack_q;
   logic                 ack_d;
   logic                 wr_lane;
   logic [DATA_W-1:0]    rd_value;
   logic [DATA_W-1:0]    readdata_q;
   logic [DATA_W-1:0]    readdata_d;
   logic                 holder_en_q;
   logic                 holder_en_d;
   logic [PIN_COUNT-1:0] dir_q;
   logic [PIN_COUNT-1:0] dir_d;
   logic [PIN_COUNT-1:0] gpio_out_q;
   logic [PIN_COUNT-1:0] gpio_out_d;
   logic [CLK_COUNT-1:0] float_q;
   logic [CLK_COUNT-1:0] float_d;

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = readdata_q;
   assign wr_lane         = avs_write & ack_q & avs_byteenable[BYTE0_LANE];

   always_comb begin
      ack_d       = (avs_read | avs_write) & ~ack_q;
      holder_en_d = holder_en_q;
      dir_d       = dir_q;
      gpio_out_d  = gpio_out_q;
      float_d     = float_q;
      rd_value    = '0;
      if (wr_lane && hit(avs_address, OFS_BUS_CTRL)) begin
         holder_en_d = avs_writedata[HOLDER_EN_BIT];
      end
      if (wr_lane && hit(avs_address, OFS_GPIO_DIR)) begin
         dir_d = avs_writedata[PIN_COUNT-1:0];
      end
      if (wr_lane && hit(avs_address, OFS_GPIO_OUT)) begin
         gpio_out_d = avs_writedata[PIN_COUNT-1:0];
      end
      if (wr_lane && hit(avs_address, OFS_GLOBAL_CTRL_1)) begin
         float_d[0] = avs_writedata[CLK_FLOAT_BIT];
      end
      if (wr_lane && hit(avs_address, OFS_GLOBAL_CTRL_2)) begin
         float_d[1] = avs_writedata[CLK_FLOAT_BIT];
      end
      // Unmapped offsets read as zero
      if (hit(avs_address, OFS_BUS_CTRL)) begin
         rd_value[HOLDER_EN_BIT] = holder_en_q;
      end else if (hit(avs_address, OFS_GPIO_DIR)) begin
         rd_value[PIN_COUNT-1:0] = dir_q;
      end else if (hit(avs_address, OFS_GPIO_OUT)) begin
         rd_value[PIN_COUNT-1:0] = gpio_out_q;
      end else if (hit(avs_address, OFS_GPIO_IN)) begin
         rd_value[PIN_COUNT-1:0] = sync_q.pad;
      end else if (hit(avs_address, OFS_GLOBAL_CTRL_1)) begin
         rd_value[CLK_FLOAT_BIT] = float_q[0];
      end else if (hit(avs_address, OFS_GLOBAL_CTRL_2)) begin
         rd_value[CLK_FLOAT_BIT] = float_q[1];
      end else if (hit(avs_address, OFS_STATUS)) begin
         rd_value[ST_FUNC_BIT]   = function_select;
         rd_value[ST_LOCKED_BIT] = (state_q != ST_RESET);
         rd_value[ST_HOLD_BIT]   = hold_s;
         rd_value[ST_OFF_BIT]    = off_s;
      end
      readdata_d = (avs_read && !ack_q) ? rd_value : readdata_q;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ack_q       <= 1'b0;
         readdata_q  <= '0;
         holder_en_q <= HOLDER_EN_RST;
         dir_q       <= GPIO_DIR_RST;
         gpio_out_q  <= GPIO_OUT_RST;
         float_q     <= CLK_FLOAT_RST;
      end else if (clk_en) begin
         ack_q       <= ack_d;
         readdata_q  <= readdata_d;
         holder_en_q <= holder_en_d;
         dir_q       <= dir_d;
         gpio_out_q  <= gpio_out_d;
         float_q     <= float_d;
      end
   end

   // Pad drive
   pad_drive_t           pad_q;
   pad_drive_t           pad_d;
   logic [PIN_COUNT-1:0] ext_addr_q;
   logic [PIN_COUNT-1:0] ext_addr_d;

   always_comb begin
      // zero until the function is live
      ext_addr_d = (state_q == ST_EXT_MEM) ? ext_mem_upper_address : EXT_ADDR_RST;
      pad_d.oe   = '0;
      pad_d.out  = '0;
      unique case (state_q)
         ST_RESET:   pad_d.oe = '0;
         ST_GPIO: begin
            pad_d.oe  = dir_q;
            pad_d.out = gpio_out_q;
         end
         ST_EXT_MEM: begin
            pad_d.oe  = '1;
            pad_d.out = ext_addr_q;
         end
         default:    pad_d.oe = '0;
      endcase
      if (hold_s || off_s) begin
         pad_d.oe = '0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pad_q      <= '0;
         ext_addr_q <= EXT_ADDR_RST;
      end else if (clk_en) begin
         pad_q      <= pad_d;
         ext_addr_q <= ext_addr_d;
      end
   end

   assign pad_drive = pad_q;

   // Memory clock outputs, half the core rate
   logic [CLK_COUNT-1:0] clk_q;
   logic [CLK_COUNT-1:0] clk_d;
   logic [CLK_COUNT-1:0] clk_oe_q;
   logic [CLK_COUNT-1:0] clk_oe_d;

   genvar gi;
   generate
      for (gi = 0; gi < CLK_COUNT; gi++) begin : g_clk
         always_comb begin
            clk_d[gi]    = ~clk_q[gi];
            clk_oe_d[gi] = (state_q != ST_RESET) && !off_s && !(hold_s && float_q[gi]);
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         clk_q    <= CLK_OUT_RST;
         clk_oe_q <= '0;
      end else if (clk_en) begin
         clk_q    <= clk_d;
         clk_oe_q <= clk_oe_d;
      end
   end

   assign ext_mem_clock_out = clk_q;
   assign ext_mem_clock_oe  = clk_oe_q;

   // Holders only act while the pad itself is released
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_keep
         bus_keeper u_keeper (
            .sys_clk    (sys_clk),
            .reset      (reset),
            .clk_en     (clk_en),
            .keep_en    (holder_en_q),
            .drive_en   (pad_q.oe[gi]),
            .drive_val  (pad_q.out[gi]),
            .keep_oe    (holder_oe[gi]),
            .keep_level (holder_level[gi])
         );
      end
   endgenerate

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   gpio_input_default_a: assert property (
      (state_q == ST_GPIO && dir_q == GPIO_DIR_RST && clk_en) |=> pad_drive.oe == '0)
      else $error("general-purpose pins driven while set as inputs");

   ext_addr_drive_a: assert property (
      (state_q == ST_EXT_MEM && !hold_s && !off_s && clk_en)
         |=> pad_drive.oe == '1 && pad_drive.out == $past(ext_addr_q))
      else $error("address pins not driven with address");

   release_float_a: assert property (
      $fell(reset) |-> pad_drive.oe == '0 && pad_drive.out == EXT_ADDR_RST)
      else $error("pins not floating at reset release");

   function_locked_a: assert property (
      (state_q != ST_RESET) |=> state_q == $past(state_q))
      else $error("pin function changed after release");

   boot_latch_a: assert property (
      (state_q == ST_RESET && clk_en)
         |=> state_q == ($past(boot_q) ? ST_EXT_MEM : ST_GPIO))
      else $error("function does not follow latched boot select");

   holder_reset_a: assert property (
      $fell(reset) |-> holder_en_q == HOLDER_EN_RST)
      else $error("bus holders not enabled after reset");

   gpio_direction_a: assert property (
      (state_q == ST_GPIO && !hold_s && !off_s && clk_en)
         |=> pad_drive.oe == $past(dir_q) && pad_drive.out == $past(gpio_out_q))
      else $error("general-purpose pins ignore direction setting");

   hold_float_a: assert property (
      (hold_s && clk_en) |=> pad_drive.oe == '0)
      else $error("pins driven during hold");

   off_float_a: assert property (
      (off_s && clk_en) |=> pad_drive.oe == '0 && ext_mem_clock_oe == '0)
      else $error("pins driven in all-float mode");

   hold_clock_runs_a: assert property (
      (hold_s && !float_q[0] && !off_s && state_q != ST_RESET && clk_en)
         |=> ext_mem_clock_oe[0] && ext_mem_clock_out[0] != $past(ext_mem_clock_out[0]))
      else $error("memory clock stopped in hold");

   hold_clock_float_a: assert property (
      (hold_s && float_q[1] && clk_en) |=> !ext_mem_clock_oe[1])
      else $error("memory clock driven in hold with float select");

   gpio_entry_c: cover property ($rose(state_q == ST_GPIO));
   ext_entry_c: cover property ($rose(state_q == ST_EXT_MEM));
   ext_hold_c: cover property (state_q == ST_EXT_MEM && hold_s ##1 !hold_s);
   keeper_c: cover property (holder_en_q && holder_oe != '0);

endmodule

// ===== hdl/upper_address_pkg.sv
package upper_address_pkg;

   localparam int PIN_COUNT = 4;
   localparam int CLK_COUNT = 2;
   localparam int ADDR_W    = 5;
   localparam int DATA_W    = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_BUS_CTRL      = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_GPIO_DIR      = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_GPIO_OUT      = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_GPIO_IN       = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_GLOBAL_CTRL_1 = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_GLOBAL_CTRL_2 = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS        = 5'h18;
   localparam int                WORD_LSB          = 2;

   // Field positions
   localparam int HOLDER_EN_BIT = 0;
   localparam int CLK_FLOAT_BIT = 0;
   localparam int ST_FUNC_BIT   = 0;
   localparam int ST_LOCKED_BIT = 1;
   localparam int ST_HOLD_BIT   = 2;
   localparam int ST_OFF_BIT    = 3;
   localparam int BYTE0_LANE    = 0;

   // Reset values
   localparam logic                 HOLDER_EN_RST = 1'b1;
   localparam logic [PIN_COUNT-1:0] GPIO_DIR_RST  = 4'h0;
   localparam logic [PIN_COUNT-1:0] GPIO_OUT_RST  = 4'h0;
   localparam logic [PIN_COUNT-1:0] EXT_ADDR_RST  = 4'h0;
   localparam logic [CLK_COUNT-1:0] CLK_FLOAT_RST = 2'h0;
   localparam logic [CLK_COUNT-1:0] CLK_OUT_RST   = 2'h0;
   localparam logic                 KEEP_RST      = 1'b0;

   typedef enum logic [1:0] {
      ST_RESET   = 2'b00,
      ST_GPIO    = 2'b01,
      ST_EXT_MEM = 2'b10
   } mux_state_t;

   typedef struct packed {
      logic                 boot_select_pin;
      logic                 hold_request_n;
      logic                 test_reset_n;
      logic                 emulation_pin_0;
      logic                 emulation_pin_1_float;
      logic [PIN_COUNT-1:0] pad;
   } pin_in_t;

   typedef struct packed {
      logic [PIN_COUNT-1:0] out;
      logic [PIN_COUNT-1:0] oe;
   } pad_drive_t;

endpackage

// ===== hdl/bus_keeper.sv
`timescale 1ns/1ps
module bus_keeper (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic keep_en,
   input  wire logic drive_en,
   input  wire logic drive_val,
   output logic      keep_oe,
   output logic      keep_level
);
   import upper_address_pkg::*;

   logic level_q;
   logic level_d;

   always_comb begin
      level_d = drive_en ? drive_val : level_q;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         level_q <= KEEP_RST;
      end else if (clk_en) begin
         level_q <= level_d;
      end
   end

   // Weak drive only while this pad's own driver is off
   assign keep_oe    = keep_en & ~drive_en;
   assign keep_level = level_q;

   keeper_holds_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      (drive_en && clk_en) ##1 (!drive_en && keep_en)
         |-> keep_oe && keep_level == $past(drive_val))
      else $error("keeper lost last driven level");

endmodule

// ===== test/far_side_pads.sv
`timescale 1ns/1ps
// Far side of the pads: a partner driver, else the holder, else a moving level
module far_side_pads (
   input  wire logic       sys_clk,
   input  wire logic       drive_en,
   input  wire logic [3:0] drive_val,
   input  wire logic [3:0] pad_out,
   input  wire logic [3:0] pad_oe,
   input  wire logic [3:0] holder_oe,
   input  wire logic [3:0] holder_level,
   output logic [3:0]      pad_level
);
   logic [3:0] float_q;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pad_oe[i])
            pad_level[i] = pad_out[i];
         else if (drive_en)
            pad_level[i] = drive_val[i];
         else if (holder_oe[i])
            pad_level[i] = holder_level[i];
         else
            pad_level[i] = float_q[i];
      end
   end
   // Undriven line never shows a stale level
   always_ff @(posedge sys_clk) begin
      float_q <= ~pad_level;
   end
endmodule

// ===== test/upper_address_pin_mux_tb.sv
`timescale 1ns/1ps
module upper_address_pin_mux_tb;
   import upper_address_pkg::*;
   typedef struct {
      logic        wr;
      logic [4:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
      logic [31:0] exp;
   } row_t;
   logic        sys_clk, reset, avs_read, avs_write, avs_waitrequest;
   logic [4:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic        boot, hold_n, trst_n, emul_0, emul_1, drive_en, function_select, clk_en;
   logic [3:0]  ext_addr, drive_val, pad_level, holder_oe, holder_level;
   logic [1:0]  clk_out, clk_oe, c;
   pin_in_t     pins_in;
   pad_drive_t  pad_drive;
   row_t        rows [9];
   int          n_fail = 0;
   int          n_checks = 0;

   assign pins_in = '{boot, hold_n, trst_n, emul_0, emul_1, pad_level};

   upper_address_pin_mux dut_u (
      .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pins_in(pins_in), .ext_mem_upper_address(ext_addr), .pad_drive(pad_drive),
      .holder_oe(holder_oe), .holder_level(holder_level), .ext_mem_clock_out(clk_out),
      .ext_mem_clock_oe(clk_oe), .function_select(function_select)
   );

   far_side_pads far_u (
      .sys_clk(sys_clk), .drive_en(drive_en), .drive_val(drive_val),
      .pad_out(pad_drive.out), .pad_oe(pad_drive.oe), .holder_oe(holder_oe),
      .holder_level(holder_level), .pad_level(pad_level)
   );

   task automatic results();
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [3:0] be,
                      input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      chk("wait cycles", 32'h2, n);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic do_reset(input logic b);
      @(posedge sys_clk);
      reset <= 1'b1;
      boot <= b;
      tick(3);
      chk("oe in reset", 32'h0, pad_drive.oe);
      @(posedge sys_clk);
      reset <= 1'b0;
      tick(3);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Whole run is under two hundred cycles
   initial begin
      repeat (4000) @(posedge sys_clk);
      n_fail++;
      results();
   end

   initial begin
      reset = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hf;
      avs_writedata = 32'h0;
      clk_en = 1'b1;
      {boot, hold_n, trst_n, emul_0, emul_1} = 5'b01111;
      {ext_addr, drive_val, drive_en} = 9'h000;
      rows = '{'{1'b0, OFS_BUS_CTRL, 4'hf, 32'h0, 32'h1},
               '{1'b0, OFS_GPIO_DIR, 4'hf, 32'h0, 32'h0},
               '{1'b1, OFS_GPIO_DIR, 4'hf, 32'hf, 32'hf},
               '{1'b1, OFS_GPIO_OUT, 4'hf, 32'ha, 32'ha},
               '{1'b1, OFS_GPIO_OUT, 4'he, 32'h5, 32'ha},
               '{1'b1, 5'h1c, 4'hf, 32'hff, 32'h0},
               '{1'b1, OFS_STATUS, 4'hf, 32'hf, 32'h2},
               '{1'b1, OFS_GLOBAL_CTRL_1, 4'hf, 32'h1, 32'h1},
               '{1'b1, OFS_GLOBAL_CTRL_2, 4'hf, 32'h0, 32'h0}};
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      tick(3);
      chk("function", 32'h0, function_select);
      chk("gpio oe", 32'h0, pad_drive.oe);
      chk("holder oe", 32'hf, holder_oe);
      foreach (rows[i]) begin
         if (rows[i].wr)
            bus(1'b1, rows[i].addr, rows[i].be, rows[i].wdata);
         bus(1'b0, rows[i].addr, 4'hf, 32'h0);
         chk("row read", rows[i].exp, rd);
      end
      tick(2);
      chk("gpio oe", 32'hf, pad_drive.oe);
      chk("gpio out", 32'ha, pad_drive.out);
      chk("holder off", 32'h0, holder_oe);
      @(posedge sys_clk);
      hold_n <= 1'b0;
      tick(4);
      chk("hold oe", 32'h0, pad_drive.oe);
      chk("clock oe", 32'h2, clk_oe);
      chk("holder level", 32'ha, holder_level);
      chk("holder hold", 32'hf, holder_oe);
      c = clk_out;
      tick(1);
      chk("clock toggle", {31'h0, ~c[1]}, {31'h0, clk_out[1]});
      bus(1'b0, OFS_STATUS, 4'hf, 32'h0);
      chk("status hold", 32'h6, rd);
      @(posedge sys_clk);
      hold_n <= 1'b1;
      tick(4);
      chk("oe after hold", 32'hf, pad_drive.oe);
      bus(1'b1, OFS_GPIO_DIR, 4'hf, 32'h0);
      @(posedge sys_clk);
      drive_val <= 4'h5;
      drive_en <= 1'b1;
      tick(3);
      bus(1'b0, OFS_GPIO_IN, 4'hf, 32'h0);
      chk("gpio in", 32'h5, rd);
      @(posedge sys_clk);
      drive_en <= 1'b0;
      bus(1'b1, OFS_BUS_CTRL, 4'hf, 32'h0);
      tick(1);
      chk("holder disabled", 32'h0, holder_oe);
      do_reset(1'b1);
      chk("function", 32'h1, function_select);
      chk("addr oe", 32'hf, pad_drive.oe);
      chk("addr out", 32'h0, pad_drive.out);
      @(posedge sys_clk);
      ext_addr <= 4'h9;
      tick(3);
      chk("addr out", 32'h9, pad_drive.out);
      // Clock enable low must freeze the memory clocks
      @(posedge sys_clk);
      clk_en <= 1'b0;
      tick(1);
      c = clk_out;
      tick(3);
      chk("frozen clock", {30'h0, c}, {30'h0, clk_out});
      @(posedge sys_clk);
      clk_en <= 1'b1;
      // Hold in address mode keeps the last address on the holders
      @(posedge sys_clk);
      hold_n <= 1'b0;
      tick(4);
      chk("addr hold oe", 32'h0, pad_drive.oe);
      chk("addr hold level", 32'h9, holder_level);
      @(posedge sys_clk);
      hold_n <= 1'b1;
      tick(4);
      // One pin short of float mode
      @(posedge sys_clk);
      trst_n <= 1'b0;
      tick(4);
      chk("near off oe", 32'hf, pad_drive.oe);
      @(posedge sys_clk);
      emul_1 <= 1'b0;
      tick(4);
      chk("off oe", 32'h0, pad_drive.oe);
      chk("off clock oe", 32'h0, clk_oe);
      @(posedge sys_clk);
      trst_n <= 1'b1;
      boot <= 1'b0;
      tick(4);
      chk("oe after off", 32'hf, pad_drive.oe);
      chk("function kept", 32'h1, function_select);
      bus(1'b0, OFS_STATUS, 4'hf, 32'h0);
      chk("status addr", 32'h3, rd);
      do_reset(1'b0);
      chk("function", 32'h0, function_select);
      results();
   end
endmodule
